//--- rtl/gtr_timer.sv
// The APB register port is this design's own decision.
`include "gtr_regs.svh"

module gtr_timer
  import gtr_pkg::*;
#(
  parameter int CW = 16,
  parameter int PW = 8
) (
  // Clock, reset and enable.
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  input wire logic clk_en_i,
  // APB slave.
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [15:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // Pins and power states.
  input wire logic external_clock_gate_pin_i,
  input wire logic lp_osc_clk_i,
  input wire logic cpu_idle_i,
  input wire logic cpu_sleep_i,
  // Interrupt and wake.
  output logic irq_o,
  output logic wake_o
);

  logic [CW-1:0] timer_count_r;
  logic [CW-1:0] timer_period_r;
  logic [15:0] timer_control_r;
  logic [15:0] oscillator_control_r;
  logic [`GTR_ST_W-1:0] status_r;
  logic [`GTR_ST_W-1:0] enable_r;
  logic [PW-1:0] presc_r;
  logic [1:0] ext_sync_r;
  logic [1:0] lp_sync_r;
  logic [1:0] idle_sync_r;
  logic [1:0] sleep_sync_r;
  logic ext_prev_r;
  logic lp_prev_r;

  // Decoded control fields.
  logic timer_on_bit;
  logic stop_in_idle_bit;
  logic gate_accumulate_enable;
  logic [1:0] prescale_select;
  logic external_sync_select;
  logic clock_source_select;
  logic low_power_osc_enable;
  assign timer_on_bit = timer_control_r[`GTR_BIT_ON];
  assign stop_in_idle_bit = timer_control_r[`GTR_BIT_SIDL];
  assign gate_accumulate_enable = timer_control_r[`GTR_BIT_GATE];
  assign prescale_select =
    timer_control_r[`GTR_BIT_PS_HI:`GTR_BIT_PS_LO];
  assign external_sync_select = timer_control_r[`GTR_BIT_SYNC];
  assign clock_source_select = timer_control_r[`GTR_BIT_CS];
  assign low_power_osc_enable = oscillator_control_r[`GTR_BIT_LPOSC];

  // Bus decode. The slave answers with no wait states.
  logic wr_en;
  logic rd_en;
  logic hit;
  assign wr_en = psel_i && penable_i && pwrite_i && clk_en_i;
  assign rd_en = psel_i && !penable_i && !pwrite_i && clk_en_i;
  always_comb begin
    unique case (paddr_i)
      `GTR_ADDR_COUNT, `GTR_ADDR_PERIOD, `GTR_ADDR_CONTROL, `GTR_ADDR_OSC,
      `GTR_ADDR_STATUS, `GTR_ADDR_CLEAR, `GTR_ADDR_ENABLE: hit = 1'b1;
      default: hit = 1'b0;
    endcase
  end

  // Pin synchronisers; the first stage feeds only the second.
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ext_sync_r <= 2'h0;
      lp_sync_r <= 2'h0;
      idle_sync_r <= 2'h0;
      sleep_sync_r <= 2'h0;
    end else if (clk_en_i) begin
      ext_sync_r <= {ext_sync_r[0], external_clock_gate_pin_i};
      lp_sync_r <= {lp_sync_r[0], lp_osc_clk_i};
      idle_sync_r <= {idle_sync_r[0], cpu_idle_i};
      sleep_sync_r <= {sleep_sync_r[0], cpu_sleep_i};
    end
  end

  logic ext_lvl;
  logic lp_lvl;
  logic idle_lvl;
  logic sleep_lvl;
  assign ext_lvl = ext_sync_r[1];
  assign lp_lvl = lp_sync_r[1];
  assign idle_lvl = idle_sync_r[1];
  assign sleep_lvl = sleep_sync_r[1];

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ext_prev_r <= 1'b0;
      lp_prev_r <= 1'b0;
    end else if (clk_en_i) begin
      ext_prev_r <= ext_lvl;
      lp_prev_r <= lp_lvl;
    end
  end

  logic ext_rise;
  logic ext_fall;
  logic lp_rise;
  assign ext_rise = ext_lvl && !ext_prev_r;
  assign ext_fall = !ext_lvl && ext_prev_r;
  assign lp_rise = lp_lvl && !lp_prev_r;

  // Source selection. The asynchronous path still passes the pin
  // synchroniser here: one clock domain trades exact edge timing for safety.
  gtr_src_type src;
  logic halted;
  always_comb begin
    halted = (idle_lvl && stop_in_idle_bit) ||
             (sleep_lvl && !(clock_source_select && !external_sync_select));
    if (!timer_on_bit || halted) begin
      src = gtr_src_none_type_e;
    end else if (clock_source_select) begin
      src = gtr_src_ext_type_e;
    end else if (gate_accumulate_enable) begin
      src = gtr_src_gated_type_e;
    end else begin
      src = gtr_src_cycle_type_e;
    end
  end

  logic tick_in;
  always_comb begin
    unique case (src)
      gtr_src_none_type_e: tick_in = 1'b0;
      gtr_src_cycle_type_e: tick_in = 1'b1;
      gtr_src_gated_type_e: tick_in = ext_lvl;
      gtr_src_ext_type_e: tick_in = low_power_osc_enable ? lp_rise : ext_rise;
    endcase
  end

  logic [PW-1:0] presc_top;
  always_comb begin
    unique case (prescale_select)
      2'b00: presc_top = `GTR_PS_DIV1;
      2'b01: presc_top = `GTR_PS_DIV8;
      2'b10: presc_top = `GTR_PS_DIV64;
      2'b11: presc_top = `GTR_PS_DIV256;
    endcase
  end

  logic count_wr;
  logic ctrl_wr;
  logic on_clear;
  logic tick;
  assign count_wr = wr_en && paddr_i == `GTR_ADDR_COUNT;
  assign ctrl_wr = wr_en && paddr_i == `GTR_ADDR_CONTROL;
  assign on_clear = ctrl_wr && timer_on_bit && !pwdata_i[`GTR_BIT_ON];
  assign tick = tick_in && presc_r == presc_top;

  // Prescaler; it only advances while the timer runs.
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      presc_r <= '0;
    end else if (clk_en_i) begin
      if (count_wr || on_clear) begin
        presc_r <= '0;
      end else if (tick_in) begin
        presc_r <= tick ? '0 : presc_r + 1'b1;
      end
    end
  end

  logic match;
  assign match = timer_count_r == timer_period_r;

  // Counter; control writes never touch it.
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      timer_count_r <= `GTR_RST_COUNT;
    end else if (clk_en_i) begin
      if (count_wr) begin
        timer_count_r <= pwdata_i[CW-1:0];
      end else if (tick) begin
        timer_count_r <= match ? '0 : timer_count_r + 1'b1;
      end
    end
  end

  // Configuration registers.
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      timer_period_r <= `GTR_RST_PERIOD;
      timer_control_r <= `GTR_RST_CONTROL;
      oscillator_control_r <= `GTR_RST_OSC;
      enable_r <= '0;
    end else if (wr_en) begin
      if (paddr_i == `GTR_ADDR_PERIOD) begin
        timer_period_r <= pwdata_i[CW-1:0];
      end
      if (ctrl_wr) begin
        timer_control_r <= pwdata_i[15:0] & `GTR_CTRL_MASK;
      end
      if (paddr_i == `GTR_ADDR_OSC) begin
        oscillator_control_r <= pwdata_i[15:0] & `GTR_OSC_MASK;
      end
      if (paddr_i == `GTR_ADDR_ENABLE) begin
        enable_r <= pwdata_i[`GTR_ST_W-1:0];
      end
    end
  end

  // Sticky events; a set in the same cycle as a clear wins.
  logic [`GTR_ST_W-1:0] ev;
  logic [`GTR_ST_W-1:0] clr;
  always_comb begin
    ev = '0;
    ev[`GTR_ST_MATCH] = tick && match;
    ev[`GTR_ST_GATE] = src == gtr_src_gated_type_e && ext_fall;
    ev[`GTR_ST_WAKE] = low_power_osc_enable && tick && match;
    clr = (wr_en && paddr_i == `GTR_ADDR_CLEAR) ?
      pwdata_i[`GTR_ST_W-1:0] : '0;
  end

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      status_r <= '0;
    end else if (clk_en_i) begin
      status_r <= (status_r & ~clr) | ev;
    end
  end

  // Interrupt and wake outputs, registered.
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      irq_o <= 1'b0;
      wake_o <= 1'b0;
    end else if (clk_en_i) begin
      irq_o <= |(((status_r & ~clr) | ev) & enable_r);
      wake_o <= ev[`GTR_ST_WAKE];
    end
  end

  // Read data captured in the setup phase.
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      prdata_o <= 32'h0000_0000;
      pslverr_o <= 1'b0;
      pready_o <= 1'b0;
    end else if (clk_en_i) begin
      pready_o <= psel_i && !penable_i;
      pslverr_o <= psel_i && !penable_i && !hit;
      if (rd_en) begin
        unique case (paddr_i)
          `GTR_ADDR_COUNT: prdata_o <= {16'h0000, timer_count_r};
          `GTR_ADDR_PERIOD: prdata_o <= {16'h0000, timer_period_r};
          `GTR_ADDR_CONTROL: prdata_o <= {16'h0000, timer_control_r};
          `GTR_ADDR_OSC: prdata_o <= {16'h0000, oscillator_control_r};
          `GTR_ADDR_STATUS: prdata_o <= {29'h0, status_r};
          `GTR_ADDR_ENABLE: prdata_o <= {29'h0, enable_r};
          default: prdata_o <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Checks.
  property p_wrap;
    @(posedge sys_clk_i) disable iff (!reset_n_i)
    (clk_en_i && tick && match && !count_wr) |=> timer_count_r == '0;
  endproperty
  a_wrap: assert property (p_wrap) else $error("no wrap");
  property p_inc;
    @(posedge sys_clk_i) disable iff (!reset_n_i)
    (clk_en_i && tick && !match && !count_wr) |=>
      timer_count_r == $past(timer_count_r) + 1'b1;
  endproperty
  a_inc: assert property (p_inc) else $error("no increment");
  property p_idle;
    @(posedge sys_clk_i) disable iff (!reset_n_i)
    (clk_en_i && idle_lvl && stop_in_idle_bit && !count_wr) |=>
      $stable(timer_count_r);
  endproperty
  a_idle: assert property (p_idle) else $error("count in idle");
  property p_ctrl;
    @(posedge sys_clk_i) disable iff (!reset_n_i)
    (ctrl_wr && !timer_on_bit) |=> $stable(timer_count_r);
  endproperty
  a_ctrl: assert property (p_ctrl) else $error("control changed count");
  property p_psclr;
    @(posedge sys_clk_i) disable iff (!reset_n_i)
    count_wr |=> presc_r == '0;
  endproperty
  a_psclr: assert property (p_psclr) else $error("prescaler kept");
  property p_off;
    @(posedge sys_clk_i) disable iff (!reset_n_i)
    (!timer_on_bit && !count_wr) |=> $stable(presc_r);
  endproperty
  a_off: assert property (p_off) else $error("prescaler moved");
  property p_flag;
    @(posedge sys_clk_i) disable iff (!reset_n_i)
    (clk_en_i && tick && match) |=> status_r[`GTR_ST_MATCH];
  endproperty
  a_flag: assert property (p_flag) else $error("flag missed");
  property p_gate;
    @(posedge sys_clk_i) disable iff (!reset_n_i)
    (clk_en_i && src == gtr_src_gated_type_e && ext_fall) |=>
      status_r[`GTR_ST_GATE] ##1 irq_o || !enable_r[`GTR_ST_GATE];
  endproperty
  a_gate: assert property (p_gate) else $error("gate flag missed");
  property p_div8;
    @(posedge sys_clk_i) disable iff (!reset_n_i)
    (tick && prescale_select == 2'b01) |-> presc_r == `GTR_PS_DIV8;
  endproperty
  a_div8: assert property (p_div8) else $error("bad ratio");
  c_wrap: cover property (@(posedge sys_clk_i) tick && match);
  c_gate: cover property (@(posedge sys_clk_i) ev[`GTR_ST_GATE]);
  c_wake: cover property (@(posedge sys_clk_i) wake_o);

endmodule // gtr_timer

//--- common/gtr_regs.svh
`ifndef GTR_REGS_SVH
`define GTR_REGS_SVH
// Register indices; each register takes one aligned 8-byte slot, two indices apart.
`define GTR_IDX_COUNT 16'h0100
`define GTR_IDX_PERIOD 16'h0102
`define GTR_IDX_CONTROL 16'h0104
`define GTR_IDX_OSC 16'h0106
`define GTR_IDX_STATUS 16'h0108
`define GTR_IDX_CLEAR 16'h010A
`define GTR_IDX_ENABLE 16'h010C
// Register byte addresses, four times the index.
`define GTR_ADDR_COUNT 16'h0400
`define GTR_ADDR_PERIOD 16'h0408
`define GTR_ADDR_CONTROL 16'h0410
`define GTR_ADDR_OSC 16'h0418
`define GTR_ADDR_STATUS 16'h0420
`define GTR_ADDR_CLEAR 16'h0428
`define GTR_ADDR_ENABLE 16'h0430
// Control register fields.
`define GTR_BIT_ON 15
`define GTR_BIT_SIDL 13
`define GTR_BIT_GATE 6
`define GTR_BIT_PS_HI 5
`define GTR_BIT_PS_LO 4
`define GTR_BIT_SYNC 2
`define GTR_BIT_CS 1
`define GTR_CTRL_MASK 16'hA076
// Oscillator control field.
`define GTR_BIT_LPOSC 1
`define GTR_OSC_MASK 16'h0002
// Status bits.
`define GTR_ST_MATCH 0
`define GTR_ST_GATE 1
`define GTR_ST_WAKE 2
`define GTR_ST_W 3
// Reset values.
`define GTR_RST_PERIOD 16'hFFFF
`define GTR_RST_CONTROL 16'h0000
`define GTR_RST_COUNT 16'h0000
`define GTR_RST_OSC 16'h0000
// Prescale terminal counts.
`define GTR_PS_DIV1 8'h00
`define GTR_PS_DIV8 8'h07
`define GTR_PS_DIV64 8'h3F
`define GTR_PS_DIV256 8'hFF
`endif

//--- common/gtr_pkg.sv
package gtr_pkg;
  // Source of counting events.
  typedef enum logic [1:0] {
    gtr_src_none_type_e,
    gtr_src_cycle_type_e,
    gtr_src_gated_type_e,
    gtr_src_ext_type_e
  } gtr_src_type;
endpackage

//--- dv/gtr_far_side.sv
module gtr_far_side (
  // Bench clock.
  input wire logic sys_clk_i,
  // Pin and oscillator lines.
  output logic pin_o,
  output logic osc_o
);
  timeunit 1ns;
  timeprecision 1ps;

  // Half period of the 32 kHz oscillator, in 10 ns cycles.
  localparam int OSC_HALF = 1526;

  // Both lines rest low, and the oscillator stands still between bursts.
  initial begin
    pin_o = 1'b0;
    osc_o = 1'b0;
  end

  // Pin or oscillator edges.
  // Each level is held at least two cycles so that the pin synchroniser
  // sees it; a gate window is one pulse with a long hold.
  // The oscillator always runs at its own half period; hold is for the pin.
  task automatic pulses(input logic use_osc, input int n, input int hold);
    int h;
    h = use_osc ? OSC_HALF : hold;
    repeat (n) begin
      repeat (h) @(posedge sys_clk_i);
      if (use_osc) osc_o <= 1'b1;
      else pin_o <= 1'b1;
      repeat (h) @(posedge sys_clk_i);
      if (use_osc) osc_o <= 1'b0;
      else pin_o <= 1'b0;
    end
  endtask
endmodule // gtr_far_side

//--- dv/gtr_timer_test.sv
`include "gtr_regs.svh"

module gtr_timer_test;
  import gtr_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  localparam logic [15:0] CNT = `GTR_ADDR_COUNT;
  localparam logic [15:0] PER = `GTR_ADDR_PERIOD;
  localparam logic [15:0] CTL = `GTR_ADDR_CONTROL;
  localparam logic [15:0] OSC = `GTR_ADDR_OSC;
  localparam logic [15:0] ST = `GTR_ADDR_STATUS;
  localparam logic [15:0] CLR = `GTR_ADDR_CLEAR;
  localparam logic [15:0] EN = `GTR_ADDR_ENABLE;

  // Bench-driven inputs and observed outputs.
  logic sys_clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [15:0] paddr = 16'h0000;
  logic [31:0] pwdata = 32'h0;
  logic idle = 1'b0, sleep = 1'b0, en = 1'b1;
  logic [31:0] prdata, q;
  logic pready, pslverr, pin, osc, irq, wake, err;
  int fails = 0, n_tests = 0, cyc = 0, wakes = 0;
  int ratio[4] = '{1, 8, 64, 256};

  always #5 sys_clk_i = ~sys_clk_i;

  gtr_timer DUT (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i),
    .clk_en_i(en), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
    .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr),
    .external_clock_gate_pin_i(pin), .lp_osc_clk_i(osc),
    .cpu_idle_i(idle), .cpu_sleep_i(sleep), .irq_o(irq), .wake_o(wake));

  gtr_far_side far (.sys_clk_i(sys_clk_i), .pin_o(pin), .osc_o(osc));

  // Wake pulses last one cycle, so they are counted here, and a hung run
  // is cut short well past the longest sequence.
  always @(posedge sys_clk_i) begin
    cyc <= cyc + 1;
    if (wake === 1'b1) wakes <= wakes + 1;
    if (cyc == 40000) begin
      fails++;
      report_and_stop();
    end
  end

  // One APB transfer; the request holds until pready is sampled high.
  task automatic apb(input logic wr, input logic [15:0] a,
                     input logic [31:0] d);
    @(posedge sys_clk_i);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk_i);
    penable <= 1'b1;
    // Only the bench timeout ends a wait that never sees pready.
    do begin
      @(posedge sys_clk_i);
    end while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input string nm, input logic [15:0] a,
                    input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(nm, e, q);
  endtask

  // Stop, zero the count and flags, then start with a new control word.
  task automatic start(input logic [31:0] c);
    wr(CTL, 32'h0);
    wr(CNT, 32'h0);
    wr(CLR, 32'h7);
    wr(CTL, c);
  endtask

  task automatic settle();
    repeat (4) @(posedge sys_clk_i);
  endtask

  task automatic report_and_stop();
    $display("Checks %0d, mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Main sequence.
  initial begin
    repeat (20) @(posedge sys_clk_i);
    reset_n_i <= 1'b1;
    rd("period_reset", PER, 32'h0000FFFF);
    rd("control_reset", CTL, 32'h0);
    rd("status_reset", ST, 32'h0);
    wr(CNT, 32'h1234);
    wr(CTL, 32'h7FFF);
    rd("control_mask", CTL, 32'h2076);
    rd("count_kept", CNT, 32'h1234);
    rd("unmapped", 16'h0110, 32'h0);
    chk("unmapped_err", 32'h1, {31'h0, err});
    // Plain timer with a short period; the flag stays while masked.
    wr(PER, 32'h3);
    wr(EN, 32'h0);
    start(32'h8000);
    repeat (12) @(posedge sys_clk_i);
    rd("match_flag", ST, 32'h1);
    chk("irq_masked", 32'h0, {31'h0, irq});
    rd("count_pre_wrap", CNT, 32'h0);
    chk("count_bound", 32'h1, {31'h0, q[15:0] <= 16'h0003});
    wr(EN, 32'h1);
    // The request launches one edge after the enable lands.
    repeat (2) @(posedge sys_clk_i);
    chk("irq_enabled", 32'h1, {31'h0, irq});
    wr(CTL, 32'h0);
    wr(CLR, 32'h1);
    @(posedge sys_clk_i);
    chk("irq_cleared", 32'h0, {31'h0, irq});
    rd("flag_cleared", ST, 32'h0);
    // Every prescale code, alternating synchronous and asynchronous.
    wr(PER, 32'hFFFF);
    for (int i = 0; i < 4; i++) begin
      start(32'h8002 | 32'(i) << 4 | 32'(i % 2) << 2);
      far.pulses(1'b0, 3 * ratio[i], 2);
      settle();
      rd("prescaled", CNT, 32'h3);
    end
    // A count write restarts the prescaler.
    start(32'h8012);
    far.pulses(1'b0, 5, 2);
    wr(CNT, 32'h0);
    far.pulses(1'b0, 3, 2);
    settle();
    rd("ps_cleared", CNT, 32'h0);
    far.pulses(1'b0, 5, 2);
    settle();
    rd("ps_restart", CNT, 32'h1);
    // Idle with and without stop-in-idle.
    start(32'hA002);
    idle <= 1'b1;
    far.pulses(1'b0, 4, 2);
    settle();
    rd("idle_stop", CNT, 32'h0);
    idle <= 1'b0;
    far.pulses(1'b0, 2, 2);
    settle();
    rd("idle_resume", CNT, 32'h2);
    start(32'h8002);
    idle <= 1'b1;
    far.pulses(1'b0, 3, 2);
    settle();
    rd("idle_run", CNT, 32'h3);
    idle <= 1'b0;
    // Sleep counts only external asynchronous edges.
    sleep <= 1'b1;
    start(32'h8006);
    far.pulses(1'b0, 3, 2);
    settle();
    rd("sleep_sync", CNT, 32'h0);
    start(32'h8002);
    far.pulses(1'b0, 3, 2);
    settle();
    rd("sleep_async", CNT, 32'h3);
    sleep <= 1'b0;
    // Gated accumulation.
    start(32'h8040);
    repeat (20) @(posedge sys_clk_i);
    rd("gate_low", CNT, 32'h0);
    far.pulses(1'b0, 1, 10);
    settle();
    rd("gate_count", CNT, 32'hA);
    chk("gate_span", 32'h1, {31'h0, q > 32'h5 && q < 32'hF});
    rd("gate_flag", ST, 32'h2);
    // Oscillator mode through sleep, with the synchronise bit zero.
    wr(PER, 32'h2);
    wr(OSC, 32'h2);
    start(32'h8002);
    far.pulses(1'b0, 3, 2);
    settle();
    rd("pin_ignored", CNT, 32'h0);
    sleep <= 1'b1;
    far.pulses(1'b1, 3, 0);
    settle();
    sleep <= 1'b0;
    rd("osc_wrap", CNT, 32'h0);
    rd("osc_flags", ST, 32'h5);
    chk("wake_pulses", 32'h1, 32'(wakes));
    // A low clock enable freezes the count: 3 ticks, period 2, ends at 0.
    start(32'h8000);
    en <= 1'b0;
    repeat (50) @(posedge sys_clk_i);
    en <= 1'b1;
    wr(CTL, 32'h0);
    rd("enable_freeze", CNT, 32'h0);
    report_and_stop();
  end
endmodule // gtr_timer_test
